/* dics_fifo.sv */
`timescale 1ns/1ps
module dics_fifo #(
  parameter int W = 20,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  // storage words live in the state record; only the pointers are cleared by reset
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } dics_fifo_regs_t;

  dics_fifo_regs_t s_reg;
  dics_fifo_regs_t s_next;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty when the low bits meet
  assign in_ready_o = (s_reg.wr[AW-1:0] != s_reg.rd[AW-1:0]) || (s_reg.wr[AW] == s_reg.rd[AW]);
  assign out_valid_o = s_reg.wr != s_reg.rd;
  assign out_data_o = s_reg.mem[s_reg.rd[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr[AW-1:0]] = in_data_i;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    if (rst_i) begin
      s_next.wr = '0;
      s_next.rd = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end
endmodule // dics_fifo

/* dics_host_model.sv */
`timescale 1ns/1ps
module dics_host_model import dics_pkg::*; #(
  parameter int LAT = 10
) (
  input wire logic clk_i,
  input wire logic side_toggle_control_start_i,
  input wire logic [1:0] mux_sel_i,
  input wire logic shift_en_i,
  output logic side_toggle_control_done_o,
  output logic [RES_W-1:0] side_toggle_control_data0_o,
  output logic [RES_W-1:0] side_toggle_control_data1_o,
  output logic shift_clk_o
);
  int cnt = 0;
  logic [1:0] mux_reg = 2'h0;
  initial begin
    side_toggle_control_done_o = 1'b0;
    shift_clk_o = 1'b0;
  end
  // results hold only at the done edge; inverted otherwise so a late sample shows
  assign side_toggle_control_data0_o = {2'b10, mux_reg, 1'b0, 15'h2A5B} ^ {RES_W{!side_toggle_control_done_o}};
  assign side_toggle_control_data1_o = {2'b10, mux_reg, 1'b1, 15'h2A5B} ^ {RES_W{!side_toggle_control_done_o}};
  always @(negedge clk_i) begin
    side_toggle_control_done_o <= (cnt == 1);
    if (side_toggle_control_start_i) begin
      cnt <= LAT;
      mux_reg <= mux_sel_i;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // own rate, unrelated phase, parked low outside frames
  always begin
    wait (shift_en_i);
    #407;
    if (shift_en_i) shift_clk_o = 1'b1;
    #393 shift_clk_o = 1'b0;
  end
endmodule // dics_host_model

/* dics_pkg.sv */
package dics_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLEAR_TIME_NS = 2000;
  localparam int CLEAR_CYC = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHANNELS = 4;
  localparam int CONVERTERS = 2;
  localparam int WORDS = 2 * CHANNELS;
  localparam int RES_W = 20;
  localparam int SHORT_W = 16;
  localparam int SR_W = WORDS * RES_W;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] BITS_LONG = 8'hA0;
  localparam logic [7:0] BITS_SHORT = 8'h80;
  localparam logic [4:0] CLEAR_LAST = 5'(CLEAR_CYC - 1);
  localparam logic [3:0] LOAD_LAST = 4'(WORDS - 1);
  localparam logic PAIR_LAST = 1'b1;

  typedef enum logic [2:0] {
    DICS_IDLE = 3'h0,
    DICS_START = 3'h1,
    DICS_SIDE_TOGGLE_CONTROL = 3'h3,
    DICS_PUSH0 = 3'h2,
    DICS_PUSH1 = 3'h6,
    DICS_CLEAR = 3'h7
  } dics_state_t;

  function automatic logic [7:0] dics_total_bits(input logic long_words);
    return long_words ? BITS_LONG : BITS_SHORT;
  endfunction
endpackage

/* dics_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - four channels, two integrators each, two converters fed by four-input muxes
// - one side is digitized while the other side integrates, without pause
// - load both sides of every channel into shift register, then assert ready low
// - sequencing on system clock waits on serial readout only when the result FIFO is full
// - after conversion, clear and charge capacitor, then wait with reference off
// - rising toggle edge closes side A input switch, starting side A integration
// - falling edge moves input to side B and presents side A to converters
// - side B converted and cleared while side A integrates
// - range code selects same feedback capacitor for every integrator
// - codes 000 to 111 map to 3 through 87.5 pF feedback capacitors
// - toggle high means side A integrates, low means side B integrates
// - word length select gives 16-bit results low, 20-bit results high
module dics_sequencer import dics_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic side_toggle_control_i,
  input wire logic [2:0] full_scale_select_i,
  input wire logic word_length_select_i,
  input wire logic serial_shift_clock_i,
  input wire logic serial_data_in_i,
  input wire logic side_toggle_control_done_i,
  input wire logic [RES_W-1:0] side_toggle_control_data0_i,
  input wire logic [RES_W-1:0] side_toggle_control_data1_i,
  output logic side_toggle_control_start_o,
  output logic [1:0] mux_sel_o,
  output logic side_a_input_switch_o,
  output logic side_b_input_switch_o,
  output logic [1:0] reference_charge_switch_o,
  output logic [1:0] capacitor_clear_switch_o,
  output logic [2:0] feedback_capacitor_o,
  output logic serial_data_o,
  output logic serial_data_n_o,
  output logic result_ready_n_o
);
  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_d;
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic din_s1;
    logic din_s2;
    logic wl_s1;
    logic wl_s2;
    logic [2:0] fs_s1;
    logic [2:0] fs_s2;
    logic integrating;
    logic int_a;
    dics_state_t st;
    logic pair;
    logic [4:0] cnt;
    logic [RES_W-1:0] res0;
    logic [RES_W-1:0] res1;
    logic [SR_W-1:0] sr;
    logic [3:0] load_cnt;
    logic [7:0] bit_cnt;
    logic ready_n;
  } dics_regs_t;

  dics_regs_t s_reg;
  dics_regs_t s_next;
  logic tog_rise;
  logic tog_fall;
  logic sclk_rise;
  logic push_valid;
  logic push_ready;
  logic [RES_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [RES_W-1:0] pop_data;
  logic [7:0] total_bits;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // toggle is nominally aligned to clk, but still treated as a pin
  assign tog_rise = s_reg.tog_s2 && !s_reg.tog_d;
  assign tog_fall = !s_reg.tog_s2 && s_reg.tog_d;
  // readout clock is only sampled; the sequence waits on it only when the FIFO is full
  assign sclk_rise = s_reg.clk_s2 && !s_reg.clk_d;
  assign total_bits = dics_total_bits(s_reg.wl_s2);

  assign push_valid = (s_reg.st == DICS_PUSH0) || (s_reg.st == DICS_PUSH1);
  assign push_data = (s_reg.st == DICS_PUSH0) ? s_reg.res0 : s_reg.res1;
  // loading is held off until the previous frame has been shifted out
  assign pop_ready = s_reg.ready_n && (s_reg.bit_cnt == 8'h00);

  dics_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  always_comb begin
    s_next = s_reg;
    s_next.tog_s1 = side_toggle_control_i;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_d = s_reg.tog_s2;
    s_next.clk_s1 = serial_shift_clock_i;
    s_next.clk_s2 = s_reg.clk_s1;
    s_next.clk_d = s_reg.clk_s2;
    s_next.din_s1 = serial_data_in_i;
    s_next.din_s2 = s_reg.din_s1;
    s_next.wl_s1 = word_length_select_i;
    s_next.wl_s2 = s_reg.wl_s1;
    s_next.fs_s1 = full_scale_select_i;
    s_next.fs_s2 = s_reg.fs_s1;

    unique case (s_reg.st)
      DICS_IDLE: begin
      end
      DICS_START: begin
        s_next.st = DICS_SIDE_TOGGLE_CONTROL;
      end
      DICS_SIDE_TOGGLE_CONTROL: begin
        if (side_toggle_control_done_i) begin
          s_next.res0 = side_toggle_control_data0_i;
          s_next.res1 = side_toggle_control_data1_i;
          s_next.st = DICS_PUSH0;
        end
      end
      DICS_PUSH0: begin
        if (push_ready) begin
          s_next.st = DICS_PUSH1;
        end
      end
      DICS_PUSH1: begin
        if (push_ready) begin
          if (s_reg.pair == PAIR_LAST) begin
            s_next.st = DICS_CLEAR;
            s_next.cnt = '0;
          end else begin
            s_next.pair = 1'b1;
            s_next.st = DICS_START;
          end
        end
      end
      DICS_CLEAR: begin
        s_next.cnt = s_reg.cnt + 5'h01;
        if (s_reg.cnt == CLEAR_LAST) begin
          s_next.st = DICS_IDLE; // reference off until next integration
        end
      end
    endcase

    // each edge swaps sides; every edge but the first digitizes the side that just stopped
    if (tog_rise || tog_fall) begin
      s_next.int_a = tog_rise;
      s_next.integrating = 1'b1;
      s_next.pair = 1'b0;
      // the very first edge has nothing integrated on the idle side
      s_next.st = s_reg.integrating ? DICS_START : DICS_IDLE;
    end

    if (pop_valid && pop_ready) begin
      if (s_reg.wl_s2) begin
        s_next.sr = {s_reg.sr[SR_W-RES_W-1:0], pop_data};
      end else begin
        s_next.sr = {s_reg.sr[SR_W-SHORT_W-1:0], pop_data[RES_W-1 -: SHORT_W]};
      end
      s_next.load_cnt = s_reg.load_cnt + 4'h1;
      if (s_reg.load_cnt == LOAD_LAST) begin
        s_next.ready_n = 1'b0;
        s_next.load_cnt = '0;
      end
    end

    if (sclk_rise && !s_reg.ready_n) begin
      // cascade data enters behind our own bits
      s_next.sr = {s_reg.sr[SR_W-2:0], s_reg.din_s2};
      s_next.bit_cnt = s_reg.bit_cnt + 8'h01;
      if (s_reg.bit_cnt == total_bits - 8'h01) begin
        s_next.bit_cnt = '0;
        s_next.ready_n = 1'b1;
      end
    end

    if (rst_i) begin
      s_next = '0;
      s_next.st = DICS_IDLE;
      s_next.ready_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign side_toggle_control_start_o = s_reg.st == DICS_START;
  // converters see the side that is not integrating
  assign mux_sel_o = {s_reg.int_a, s_reg.pair};
  assign side_a_input_switch_o = s_reg.integrating && s_reg.int_a;
  assign side_b_input_switch_o = s_reg.integrating && !s_reg.int_a;
  assign reference_charge_switch_o = (s_reg.st == DICS_CLEAR) ? {s_reg.int_a, !s_reg.int_a} : 2'h0;
  assign capacitor_clear_switch_o = reference_charge_switch_o;
  assign feedback_capacitor_o = s_reg.fs_s2; // one code for all eight integrators
  assign serial_data_o = s_reg.wl_s2 ? s_reg.sr[SR_W-1] : s_reg.sr[WORDS*SHORT_W-1];
  assign serial_data_n_o = !serial_data_o;
  assign result_ready_n_o = s_reg.ready_n;

  a_rise_side_a: assert property (tog_rise |=> side_a_input_switch_o && !side_b_input_switch_o)
    else $error("side A not integrating after rising toggle");
  a_fall_side_b: assert property (tog_fall |=> side_b_input_switch_o && mux_sel_o[1] == 1'b0)
    else $error("side B not integrating or side A not muxed after falling toggle");
  a_switch_exclusive: assert property (!(side_a_input_switch_o && side_b_input_switch_o))
    else $error("both input switches closed");
  a_mux_opposite: assert property (side_toggle_control_start_o |-> mux_sel_o[1] == side_a_input_switch_o)
    else $error("converter fed from integrating side");
  a_cap_follows: assert property (##3 feedback_capacitor_o == $past(full_scale_select_i, 2))
    else $error("feedback capacitor code does not follow range input");
  a_clear_hold: assert property ($rose(capacitor_clear_switch_o != 2'h0) && !tog_rise && !tog_fall
      |-> (capacitor_clear_switch_o != 2'h0) [*8])
    else $error("clear phase ended early");
  a_clear_side: assert property (capacitor_clear_switch_o != 2'h0
      |-> (capacitor_clear_switch_o[1] == side_a_input_switch_o))
    else $error("clearing the integrating side");
  a_ready_full: assert property ($fell(result_ready_n_o) |-> $past(s_reg.load_cnt) == LOAD_LAST)
    else $error("ready asserted before all results loaded");
  a_frame_len: assert property (s_reg.bit_cnt < total_bits)
    else $error("shift count beyond word length");
  a_seq_indep: assert property (s_reg.st == DICS_IDLE && !tog_rise && !tog_fall |=> s_reg.st == DICS_IDLE)
    else $error("sequencer moved without toggle edge");

  c_full_cycle: cover property (tog_fall ##[1:200] capacitor_clear_switch_o[0]);
  c_ready: cover property ($fell(result_ready_n_o));
  c_frame_out: cover property ($rose(result_ready_n_o) && !word_length_select_i);
  c_fifo_stall: cover property (push_valid && !push_ready);
endmodule // dics_sequencer

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import dics_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, tog = 1'b0, wl = 1'b1, shift_en = 1'b0;
  logic [2:0] fs = 3'h0;
  logic side_toggle_control_done, side_toggle_control_start, sclk, sd, sd_n, rdy_n, sw_a, sw_b;
  logic [RES_W-1:0] d0, d1;
  logic [1:0] mux, refsw, clrsw, clr_side = 2'h0;
  logic [2:0] fcap;
  int n_fail = 0, n_tests = 0, cyc = 0, n_clr = 0, n_side_toggle_control = 0;
  always #50 clk_i = ~clk_i;
  dics_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .side_toggle_control_i(tog), .full_scale_select_i(fs),
    .word_length_select_i(wl), .serial_shift_clock_i(sclk), .serial_data_in_i(1'b0),
    .side_toggle_control_done_i(side_toggle_control_done), .side_toggle_control_data0_i(d0), .side_toggle_control_data1_i(d1), .side_toggle_control_start_o(side_toggle_control_start),
    .mux_sel_o(mux), .side_a_input_switch_o(sw_a), .side_b_input_switch_o(sw_b),
    .reference_charge_switch_o(refsw), .capacitor_clear_switch_o(clrsw), .feedback_capacitor_o(fcap),
    .serial_data_o(sd), .serial_data_n_o(sd_n), .result_ready_n_o(rdy_n));
  dics_host_model host (.clk_i(clk_i), .side_toggle_control_start_i(side_toggle_control_start), .mux_sel_i(mux), .shift_en_i(shift_en),
    .side_toggle_control_done_o(side_toggle_control_done), .side_toggle_control_data0_o(d0), .side_toggle_control_data1_o(d1), .shift_clk_o(sclk));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // clear phase counted only on the converted side, with both switch sets agreeing
  always @(negedge clk_i) begin
    cyc++;
    if (refsw == clr_side && clrsw == refsw) n_clr++;
    if (side_toggle_control_start) n_side_toggle_control++;
    if (cyc == 12000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic t_reset();
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    check("ready_n", rdy_n, 1);
    check("switch_a", sw_a, 0);
    check("switch_b", sw_b, 0);
    check("side_toggle_control_start", side_toggle_control_start, 0);
    check("serial_data_n", sd_n, 1);
    // shift edges without a frame must not move the output
    shift_en = 1'b1;
    repeat (40) @(negedge clk_i);
    shift_en = 1'b0;
    check("serial_data idle", sd, 0);
    check("ready_n idle", rdy_n, 1);
    $display("reset test done");
  endtask
  task automatic t_range();
    for (int c = 0; c < 8; c++) begin
      fs = 3'(c);
      repeat (3) @(negedge clk_i);
      check("feedback_cap", fcap, c);
    end
    $display("range test done");
  endtask
  task automatic edge_run(input logic v, input int convs);
    @(negedge clk_i);
    n_clr = 0;
    n_side_toggle_control = 0;
    clr_side = (convs == 0) ? 2'h3 : (v ? 2'h2 : 2'h1);
    @(posedge clk_i);
    tog <= v;
    repeat (6) @(negedge clk_i);
    check("switch_a", sw_a, v);
    check("switch_b", sw_b, !v);
    if (convs != 0) check("mux side", mux[1], v);
    repeat (90) @(negedge clk_i);
    check("conversions", n_side_toggle_control, convs);
    check("clear cycles", n_clr, (convs == 0) ? 0 : CLEAR_CYC);
  endtask
  task automatic t_frame(input logic lng, input logic first);
    int len;
    int i;
    logic [RES_W-1:0] word;
    len = lng ? RES_W : SHORT_W;
    wl = lng;
    if (first) edge_run(1'b1, 0);
    edge_run(1'b0, 2);
    edge_run(1'b1, 2);
    i = 0;
    while (rdy_n !== 1'b0 && i < 200) begin
      @(negedge clk_i);
      i++;
    end
    check("ready_n", rdy_n, 0);
    shift_en = 1'b1;
    for (i = 0; i < 8 * len; i++) begin
      word = {2'b10, 3'(i / len), 15'h2A5B};
      check("serial_data", sd, word[RES_W - 1 - i % len]);
      check("serial_data_n", sd_n, !word[RES_W - 1 - i % len]);
      @(posedge sclk);
      #700;
    end
    shift_en = 1'b0;
    check("ready_n end", rdy_n, 1);
    $display("frame test with %0d-bit words done", len);
  endtask
  initial begin
    t_reset();
    t_range();
    t_frame(1'b1, 1'b1);
    t_frame(1'b0, 1'b0);
    end_of_test();
  end
endmodule // tb
